// file: rtl/pmon_map.svh
// Register map, field positions, reset values and codes of the result register bank
`ifndef PMON_MAP_SVH
`define PMON_MAP_SVH
`define ADDR_CONVERTER_SETTINGS 4'h1
`define ADDR_SHUNT_CALIBRATION 4'h2
`define ADDR_SHUNT_VOLTAGE 4'h4
`define ADDR_BUS_VOLTAGE 4'h5
`define RST_CONVERTER_SETTINGS 16'hfb68
`define RST_SHUNT_CALIBRATION 15'h1000
`define RST_RESULT 16'h0000
`define CAL_MSB 14
`define MODE_MSB 15
`define MODE_LSB 12
`define AVG_MSB 2
`define AVG_LSB 0
`define RANGE_BIT 4
`define MODE_ALL_CONT 4'hf
`define MODE_OFF_A 4'h0
`define MODE_OFF_B 4'h8
`define MODE_CONT_BIT 3
`define EN_BUS_BIT 0
`define EN_SHUNT_BIT 1
`define EN_TEMP_BIT 2
`define SHUNT_LSB_NV_RANGE0 16'h1388
`define SHUNT_LSB_NV_RANGE1 16'h04e2
`define BUS_LSB_UV 16'h0c35
`define COUNT_W 11
`endif

// file: rtl/pmon_pkg.sv
// Types shared by the result register bank
package pmon_pkg;
  typedef logic [15:0] word_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [2:0] avg_code_t;
  typedef logic [3:0] mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCUM = 2'b01,
    ST_PUBLISH = 2'b11
  } avg_state_t;
endpackage

// file: rtl/pmon_average.sv
// Sample averaging engine that publishes one result per finished run
`timescale 1ns/10ps
`include "pmon_map.svh"
module pmon_average (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire pmon_pkg::avg_code_t avg_code,
  input wire logic enable,
  // Sample in
  input wire logic sample_valid,
  input wire pmon_pkg::word_t sample,
  // Averaged result
  output pmon_pkg::word_t result,
  output logic result_valid
);
  import pmon_pkg::*;

  avg_state_t state;
  logic [`COUNT_W-1:0] count;
  logic [`COUNT_W-1:0] target;
  logic signed [26:0] acc;
  logic [3:0] shift;
  logic signed [26:0] next_acc;

  // Sample count and divide shift for each averaging code
  always_comb begin
    unique case (avg_code)
      3'h0: begin target = 11'h001; shift = 4'h0; end
      3'h1: begin target = 11'h004; shift = 4'h2; end
      3'h2: begin target = 11'h010; shift = 4'h4; end
      3'h3: begin target = 11'h040; shift = 4'h6; end
      3'h4: begin target = 11'h080; shift = 4'h7; end
      3'h5: begin target = 11'h100; shift = 4'h8; end
      3'h6: begin target = 11'h200; shift = 4'h9; end
      3'h7: begin target = 11'h400; shift = 4'ha; end
    endcase
  end

  assign next_acc = acc + 27'(signed'(sample));

  // Accumulate; publish once the count reaches the current code's target, so a code change acts on the run in progress
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      count <= 11'h000;
      acc <= 27'sh0;
      result <= 16'h0000;
      result_valid <= 1'b0;
    end else if (ce) begin
      result_valid <= 1'b0;
      unique case (state)
        ST_IDLE, ST_ACCUM: begin
          if (enable && sample_valid) begin
            acc <= next_acc;
            count <= count + 11'h001;
            // At or past target, so a code lowered mid-run cannot run on to a wrap
            state <= (count + 11'h001 >= target) ? ST_PUBLISH : ST_ACCUM;
          end
        end
        ST_PUBLISH: begin
          result <= 16'(acc >>> shift);
          result_valid <= 1'b1;
          acc <= 27'sh0;
          count <= 11'h000;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  a_avg_publish: assert property (@(posedge clk) disable iff (rst)
    ce && state == ST_PUBLISH |=> result_valid && count == 11'h000)
    else $error("publish did not raise result valid");
  // A low clock enable holds the publish flag up, which is no new run
  a_avg_quiet: assert property (@(posedge clk) disable iff (rst)
    result_valid |-> $past(state) == ST_PUBLISH || !$past(ce))
    else $error("result valid without a finished run");
endmodule

// file: rtl/pmon_result_regs.sv
// Converter settings, shunt calibration and voltage result registers of the power monitor
//
// Function
// - Averaging field codes 0 to 7 select 1, 4, 16, 64, 128, 256, 512 or 1024 samples.
// - One averaging count applies to the shunt and bus inputs enabled by the mode.
// - With a nonzero code, results update only after the full averaging run.
// - Calibration bit 15 is reserved and always reads zero.
// - A 15-bit writable calibration constant resets to 1000h and scales current.
// - The calibration constant sets the current result scaling and LSB weight.
// - Shunt voltage result is a read-only 16-bit two's complement value.
// - Shunt LSB is 5 uV with range select 0 and 1.25 uV with range select 1.
// - Shunt result sits at address 4h and clears to zero on reset.
// - Bus voltage result is read-only two's complement with sign bit always zero.
// - Each bus voltage LSB is 3.125 mV.
// - A 4-bit mode selects shutdown, single-shot or continuous inputs; resets to Fh.
`timescale 1ns/10ps
`include "pmon_map.svh"
module pmon_result_regs (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Register access from the serial interface
  input wire pmon_pkg::reg_addr_t REG_ADDR,
  input wire logic REG_WR,
  input wire pmon_pkg::word_t REG_WDATA,
  output pmon_pkg::word_t REG_RDATA,
  // Converter samples
  input wire logic SHUNT_SAMPLE_VALID,
  input wire pmon_pkg::word_t SHUNT_SAMPLE,
  input wire logic BUS_SAMPLE_VALID,
  input wire pmon_pkg::word_t BUS_SAMPLE,
  // Settings to converter and current math
  output pmon_pkg::mode_t MODE,
  output pmon_pkg::avg_code_t SAMPLE_AVERAGE_COUNT,
  output logic SHUNT_INPUT_RANGE_SELECT,
  output logic [14:0] CURRENT_SCALE,
  output logic [15:0] SHUNT_LSB_NV,
  output logic [15:0] BUS_LSB_UV,
  output logic TRIGGER,
  output logic SHUNT_ENABLE,
  output logic BUS_ENABLE,
  output logic TEMP_ENABLE
);
  import pmon_pkg::*;

  word_t converter_settings;
  logic [14:0] shunt_calibration;
  word_t shunt_voltage_result;
  word_t bus_voltage_result;
  word_t shunt_avg;
  word_t bus_avg;
  logic shunt_avg_valid;
  logic bus_avg_valid;
  logic single_done;
  logic active;

  assign MODE = converter_settings[`MODE_MSB:`MODE_LSB];
  assign SAMPLE_AVERAGE_COUNT = converter_settings[`AVG_MSB:`AVG_LSB];
  assign SHUNT_INPUT_RANGE_SELECT = converter_settings[`RANGE_BIT];

  // Shutdown codes and spent single shots disable every input
  assign active = (MODE != `MODE_OFF_A) && (MODE != `MODE_OFF_B)
    && (MODE[`MODE_CONT_BIT] || !single_done);
  assign BUS_ENABLE = active && MODE[`EN_BUS_BIT];
  assign SHUNT_ENABLE = active && MODE[`EN_SHUNT_BIT];
  assign TEMP_ENABLE = active && MODE[`EN_TEMP_BIT];

  // Settings register; a write of a single-shot mode fires a trigger pulse
  always_ff @(posedge CLK) begin
    if (RST) begin
      converter_settings <= `RST_CONVERTER_SETTINGS;
      TRIGGER <= 1'b0;
    end else if (CE) begin
      TRIGGER <= 1'b0;
      if (REG_WR && REG_ADDR == `ADDR_CONVERTER_SETTINGS) begin
        converter_settings <= REG_WDATA;
        TRIGGER <= !REG_WDATA[`MODE_MSB] && (REG_WDATA[`MODE_MSB:`MODE_LSB] != `MODE_OFF_A);
      end
    end
  end

  // Single shot ends in a cycle where every enabled shunt and bus input publishes at once; the temperature input is not waited on
  always_ff @(posedge CLK) begin
    if (RST) begin
      single_done <= 1'b0;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == `ADDR_CONVERTER_SETTINGS) begin
        single_done <= 1'b0;
      end else if (!MODE[`MODE_CONT_BIT]
          && (shunt_avg_valid || !MODE[`EN_SHUNT_BIT])
          && (bus_avg_valid || !MODE[`EN_BUS_BIT])
          && (shunt_avg_valid || bus_avg_valid)) begin
        single_done <= 1'b1;
      end
    end
  end

  // Calibration constant, bit 15 never stored
  always_ff @(posedge CLK) begin
    if (RST) begin
      shunt_calibration <= `RST_SHUNT_CALIBRATION;
    end else if (CE && REG_WR && REG_ADDR == `ADDR_SHUNT_CALIBRATION) begin
      shunt_calibration <= REG_WDATA[`CAL_MSB:0];
    end
  end
  assign CURRENT_SCALE = shunt_calibration;

  // Both channels share the one averaging code
  pmon_average u_shunt_avg (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .avg_code(SAMPLE_AVERAGE_COUNT),
    .enable(SHUNT_ENABLE),
    .sample_valid(SHUNT_SAMPLE_VALID),
    .sample(SHUNT_SAMPLE),
    .result(shunt_avg),
    .result_valid(shunt_avg_valid)
  );
  pmon_average u_bus_avg (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .avg_code(SAMPLE_AVERAGE_COUNT),
    .enable(BUS_ENABLE),
    .sample_valid(BUS_SAMPLE_VALID),
    .sample(BUS_SAMPLE),
    .result(bus_avg),
    .result_valid(bus_avg_valid)
  );

  // Results load only from the averager; host writes have no path here
  always_ff @(posedge CLK) begin
    if (RST) begin
      shunt_voltage_result <= `RST_RESULT;
    end else if (CE && shunt_avg_valid) begin
      shunt_voltage_result <= shunt_avg;
    end
  end

  // Negative bus readings clamp to zero so the sign bit stays clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_voltage_result <= `RST_RESULT;
    end else if (CE && bus_avg_valid) begin
      bus_voltage_result <= bus_avg[15] ? `RST_RESULT : bus_avg;
    end
  end

  // LSB weights for downstream conversion, in nV and uV
  assign SHUNT_LSB_NV = SHUNT_INPUT_RANGE_SELECT ? `SHUNT_LSB_NV_RANGE1
    : `SHUNT_LSB_NV_RANGE0;
  assign BUS_LSB_UV = `BUS_LSB_UV;

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else if (CE) begin
      unique case (REG_ADDR)
        `ADDR_CONVERTER_SETTINGS: REG_RDATA <= converter_settings;
        `ADDR_SHUNT_CALIBRATION: REG_RDATA <= {1'b0, shunt_calibration};
        `ADDR_SHUNT_VOLTAGE: REG_RDATA <= shunt_voltage_result;
        `ADDR_BUS_VOLTAGE: REG_RDATA <= bus_voltage_result;
        default: REG_RDATA <= 16'h0000;
      endcase
    end
  end

  // Guards on register access, held results and fixed weights
  a_cal_bit15: assert property (@(posedge CLK) disable iff (RST)
    REG_ADDR == `ADDR_SHUNT_CALIBRATION && CE |=> !REG_RDATA[15])
    else $error("calibration bit 15 read nonzero");
  a_cal_write: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_WR && REG_ADDR == `ADDR_SHUNT_CALIBRATION
    |=> shunt_calibration == $past(REG_WDATA[14:0]))
    else $error("calibration write lost");
  a_shunt_hold: assert property (@(posedge CLK) disable iff (RST)
    !shunt_avg_valid |=> $stable(shunt_voltage_result))
    else $error("shunt result changed without a finished run");
  a_bus_sign: assert property (@(posedge CLK) disable iff (RST)
    !bus_voltage_result[15])
    else $error("bus result sign bit set");
  a_shunt_load: assert property (@(posedge CLK) disable iff (RST)
    CE && shunt_avg_valid |=> shunt_voltage_result == $past(shunt_avg))
    else $error("shunt result not loaded");
  a_range_lsb: assert property (@(posedge CLK) disable iff (RST)
    SHUNT_LSB_NV == (SHUNT_INPUT_RANGE_SELECT ? 16'h04e2 : 16'h1388))
    else $error("shunt lsb weight wrong");
  a_shutdown_off: assert property (@(posedge CLK) disable iff (RST)
    (MODE == 4'h0 || MODE == 4'h8) |-> !SHUNT_ENABLE && !BUS_ENABLE)
    else $error("input enabled in shutdown");
  a_shared_avg: assert property (@(posedge CLK) disable iff (RST)
    u_shunt_avg.target == u_bus_avg.target)
    else $error("channels use different averaging counts");
  a_bus_lsb: assert property (@(posedge CLK) BUS_LSB_UV == 16'h0c35)
    else $error("bus lsb weight wrong");
  a_cal_scale: assert property (@(posedge CLK) CURRENT_SCALE == shunt_calibration)
    else $error("current scale differs from calibration");
  a_bus_hold: assert property (@(posedge CLK) disable iff (RST)
    !bus_avg_valid |=> $stable(bus_voltage_result))
    else $error("bus result changed without a finished run");
  a_avg_code_write: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_WR && REG_ADDR == `ADDR_CONVERTER_SETTINGS
    |=> SAMPLE_AVERAGE_COUNT == $past(REG_WDATA[2:0]))
    else $error("averaging code write lost");
  a_trigger_fire: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_WR && REG_ADDR == `ADDR_CONVERTER_SETTINGS
    && (REG_WDATA[15:12] inside {[4'h1:4'h7]}) |=> TRIGGER)
    else $error("single shot write gave no trigger");
  a_single_stop: assert property (@(posedge CLK) disable iff (RST)
    single_done && !MODE[3] |-> !SHUNT_ENABLE && !BUS_ENABLE && !TEMP_ENABLE)
    else $error("input still enabled after single shot");
  a_ce_freeze: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(converter_settings) && $stable(shunt_calibration) && $stable(REG_RDATA))
    else $error("state moved with clock enable low");

  // Main scenarios worth seeing at least once
  c_shunt_publish: cover property (@(posedge CLK) disable iff (RST) shunt_avg_valid);
  c_bus_publish: cover property (@(posedge CLK) disable iff (RST) bus_avg_valid);
  c_single_shot: cover property (@(posedge CLK) disable iff (RST) TRIGGER ##[1:50] single_done);
  c_long_run: cover property (@(posedge CLK) disable iff (RST)
    shunt_avg_valid && SAMPLE_AVERAGE_COUNT == 3'h7);
  c_bus_clamp: cover property (@(posedge CLK) disable iff (RST) bus_avg_valid && bus_avg[15]);
endmodule

// file: verif/pmon_sample_source.sv
// Converter model that feeds raw samples to one input of the bank
`timescale 1ns/10ps
module pmon_sample_source (
  // Clock
  input wire logic clk,
  // Sample out
  output logic valid,
  output pmon_pkg::word_t sample
);
  import pmon_pkg::*;
  word_t last;
  // Quiet at start
  initial begin
    valid = 1'b0;
    sample = 16'h0000;
    last = 16'h0000;
  end
  // Gap after each sample keeps clear of the publish cycle, which drops input
  task automatic send(input int n, input word_t value);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      valid = 1'b1;
      sample = value;
      last = value;
      @(negedge clk);
      valid = 1'b0;
      sample = ~last; // Stale data must not pass for valid
    end
  endtask
endmodule

// file: verif/tb_pmon_result_regs.sv
// Self-checking bench for the settings, calibration and voltage result registers
`timescale 1ns/10ps
module tb_pmon_result_regs;
  import pmon_pkg::*;
  logic CLK, RST, CE, REG_WR, SHUNT_SAMPLE_VALID, BUS_SAMPLE_VALID;
  logic SHUNT_INPUT_RANGE_SELECT, TRIGGER, SHUNT_ENABLE, BUS_ENABLE, TEMP_ENABLE;
  reg_addr_t REG_ADDR;
  word_t REG_WDATA, REG_RDATA, SHUNT_SAMPLE, BUS_SAMPLE, vs, vb, prev_s;
  mode_t MODE;
  avg_code_t SAMPLE_AVERAGE_COUNT;
  logic [14:0] CURRENT_SCALE;
  logic [15:0] SHUNT_LSB_NV, BUS_LSB_UV;
  int miscompares, n_tests;
  int cnt[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
  pmon_result_regs u_pmon_result_regs (.CLK(CLK), .RST(RST), .CE(CE),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SHUNT_SAMPLE_VALID(SHUNT_SAMPLE_VALID), .SHUNT_SAMPLE(SHUNT_SAMPLE),
    .BUS_SAMPLE_VALID(BUS_SAMPLE_VALID), .BUS_SAMPLE(BUS_SAMPLE), .MODE(MODE),
    .SAMPLE_AVERAGE_COUNT(SAMPLE_AVERAGE_COUNT),
    .SHUNT_INPUT_RANGE_SELECT(SHUNT_INPUT_RANGE_SELECT), .CURRENT_SCALE(CURRENT_SCALE),
    .SHUNT_LSB_NV(SHUNT_LSB_NV), .BUS_LSB_UV(BUS_LSB_UV), .TRIGGER(TRIGGER),
    .SHUNT_ENABLE(SHUNT_ENABLE), .BUS_ENABLE(BUS_ENABLE), .TEMP_ENABLE(TEMP_ENABLE));
  pmon_sample_source u_shunt_source (.clk(CLK), .valid(SHUNT_SAMPLE_VALID),
    .sample(SHUNT_SAMPLE));
  pmon_sample_source u_bus_source (.clk(CLK), .valid(BUS_SAMPLE_VALID), .sample(BUS_SAMPLE));
  // Clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register access: one-cycle write strobe, registered read data
  task automatic wr(input reg_addr_t a, input word_t v);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rdchk(input reg_addr_t a, input word_t exp);
    @(negedge CLK);
    REG_ADDR = a;
    repeat (2) @(negedge CLK);
    chk(REG_RDATA, exp);
  endtask
  task automatic en_chk(input logic [2:0] exp);
    chk({13'h0000, SHUNT_ENABLE, BUS_ENABLE, TEMP_ENABLE}, {13'h0000, exp});
  endtask
  // Watchdog so a hang still ends in the report
  initial begin
    repeat (100000) @(posedge CLK);
    miscompares++;
    $display("[ERR] %0t run did not finish", $time);
    report_and_stop();
  end
  // Main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    CE = 1'b1;
    RST = 1'b1;
    REG_WR = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 16'h0000;
    repeat (3) @(negedge CLK);
    RST = 1'b0;
    rdchk(4'h1, 16'hfb68);
    chk({12'h000, MODE}, 16'h000f);
    rdchk(4'h2, 16'h1000);
    rdchk(4'h4, 16'h0000);
    rdchk(4'h5, 16'h0000);
    wr(4'h2, 16'hffff);
    rdchk(4'h2, 16'h7fff);
    chk({1'b0, CURRENT_SCALE}, 16'h7fff);
    wr(4'h2, 16'h8abc);
    rdchk(4'h2, 16'h0abc);
    // A write while the clock enable is low must not land
    CE = 1'b0;
    wr(4'h2, 16'h0123);
    CE = 1'b1;
    rdchk(4'h2, 16'h0abc);
    // Range select and fixed weights
    wr(4'h1, 16'hf010);
    chk({15'h0000, SHUNT_INPUT_RANGE_SELECT}, 16'h0001);
    chk(SHUNT_LSB_NV, 16'h04e2);
    wr(4'h1, 16'hf000);
    chk(SHUNT_LSB_NV, 16'h1388);
    chk(BUS_LSB_UV, 16'h0c35);
    // Mode decides the enabled inputs; single-shot writes pulse the trigger
    en_chk(3'b111);
    wr(4'h1, 16'h8000);
    en_chk(3'b000);
    chk({15'h0000, TRIGGER}, 16'h0000);
    wr(4'h1, 16'h1000);
    en_chk(3'b010);
    chk({15'h0000, TRIGGER}, 16'h0001);
    u_bus_source.send(1, 16'h0042);
    repeat (3) @(negedge CLK);
    en_chk(3'b000);
    // Every averaging code, constant input so the average is exact
    prev_s = 16'h0000;
    for (int c = 0; c < 8; c++) begin
      vs = 16'h8001 + 16'(c);
      vb = 16'h0101 + 16'(c);
      wr(4'h1, {4'hf, 9'h000, c[2:0]});
      chk({13'h0000, SAMPLE_AVERAGE_COUNT}, 16'(c));
      if (cnt[c] > 1) begin
        fork
          u_shunt_source.send(cnt[c] - 1, vs);
          u_bus_source.send(cnt[c] - 1, vb);
        join
        repeat (3) @(negedge CLK);
        rdchk(4'h4, prev_s);
      end
      fork
        u_shunt_source.send(1, vs);
        u_bus_source.send(1, vb);
      join
      repeat (2) @(negedge CLK);
      rdchk(4'h4, vs);
      rdchk(4'h5, vb);
      prev_s = vs;
    end
    // Writes to results and unmapped places change nothing
    wr(4'h4, 16'h1234);
    wr(4'h5, 16'h1234);
    wr(4'hc, 16'hffff);
    rdchk(4'h4, vs);
    rdchk(4'h5, vb);
    rdchk(4'hc, 16'h0000);
    // Negative bus average is stored as zero
    wr(4'h1, 16'hf000);
    u_bus_source.send(1, 16'hfff0);
    repeat (2) @(negedge CLK);
    rdchk(4'h5, 16'h0000);
    // Second reset brings back the calibration, shunt result and settings defaults
    RST = 1'b1;
    repeat (3) @(negedge CLK);
    RST = 1'b0;
    rdchk(4'h2, 16'h1000);
    rdchk(4'h4, 16'h0000);
    rdchk(4'h1, 16'hfb68);
    report_and_stop();
  end
endmodule
